// ### design/phs_pkg.sv
// Overview of operation
// - full mode starts a transfer only with request clear and flag ready.
// - input transfer drives direction high before raising the request.
// - flag going ready to busy clears the request in every mode.
// - full mode ready-edge latch ignores the busy edge and captures on busy to ready.
// - pulse mode skips the flag check; request clear is enough.
// - output drives direction low, sets data, waits request delay, then requests.
// - pulse mode ready-edge latch: data is valid when flag goes busy.
// - output data stays valid while the request is set.
// - ready pulses output: flag ready then busy; busy edge clears request.
// - interface reset pulses peripheral reset low for at least 15 us.
// - interface reset clears the request and abandons the handshake.
// - interface reset zeroes output data only when the clear option is fitted.
// - interface reset clears the interrupt enable bit.
// - interface reset keeps both aux control lines and the direction line.
// - request and flag polarity selectable; direction high for input.
// - busy-edge latch captures input data on the flag's busy transition.
// - optional status check before a sequence; not-OK reports error, no transfer.
package phs_pkg;

  localparam int DATA_W = 16;
  localparam int DELAY_W = 8;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PRESET_MIN_NS = 15000;
  // least time: round up
  localparam int PRESET_CYCLES = (PRESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESET_W = 9;
  localparam logic [PRESET_W-1:0] PRESET_LOAD = PRESET_W'(PRESET_CYCLES);
  localparam logic [DATA_W-1:0] DOUT_RESET = 16'h0000;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 8'h00;

  typedef enum logic [2:0] {
    PHS_IDLE,
    PHS_SETUP,
    PHS_DELAY,
    PHS_REQ,
    PHS_WAIT_RDY
  } phs_state_t;

  typedef struct packed {
    logic pulse_mode;
    logic latch_on_flag_busy;
    logic req_active_high;
    logic flag_busy_high;
    logic status_check_en;
    logic status_ok_high;
    logic dout_clear_fitted;
    logic [DELAY_W-1:0] req_delay;
  } phs_cfg_t;

  typedef struct packed {
    phs_state_t state;
    logic req_set;
    logic dir_in;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] din;
    logic [DELAY_W-1:0] delay_cnt;
    logic [PRESET_W-1:0] rst_cnt;
    logic preset_n;
    logic int_en;
    logic aux_a;
    logic aux_b;
    logic flag_busy_q;
    logic done;
    logic status_err;
  } phs_regs_t;

endpackage

// ### design/phs_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module phs_pin_sync
  import phs_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  // packed as {s1, s2, s3, q}; s1 feeds only s2
  logic [4*W-1:0] st_reg;
  logic [4*W-1:0] st_next;

  always_comb begin
    st_next[4*W-1:3*W] = pin_in;
    st_next[3*W-1:2*W] = st_reg[4*W-1:3*W];
    st_next[2*W-1:W] = st_reg[3*W-1:2*W];
    // a bit changes only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st_reg[2*W+i] == st_reg[W+i]) begin
        st_next[i] = st_reg[W+i];
      end else begin
        st_next[i] = st_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_out = st_reg[W-1:0];

endmodule
`default_nettype wire

// ### design/phs_port.sv
`timescale 1ns/1ps
`default_nettype none
module phs_port
  import phs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire phs_cfg_t cfg,
  input wire logic iface_reset,
  input wire logic xfer_valid,
  input wire logic xfer_dir_in,
  input wire logic xfer_first,
  input wire logic [DATA_W-1:0] xfer_wdata,
  output logic xfer_ready,
  output logic xfer_done,
  output logic status_error,
  output logic [DATA_W-1:0] xfer_rdata,
  input wire logic int_enable_set,
  output logic int_enable,
  input wire logic aux_write,
  input wire logic aux_a_in,
  input wire logic aux_b_in,
  output logic aux_control_out_a,
  output logic aux_control_out_b,
  input wire logic periph_flag,
  input wire logic periph_ok_status,
  input wire logic [DATA_W-1:0] periph_din,
  output logic xfer_request,
  output logic periph_dir_in,
  output logic periph_reset_n,
  output logic [DATA_W-1:0] periph_dout
);

  phs_regs_t r_reg;
  phs_regs_t r_next;
  logic [DATA_W+1:0] sync_q;
  logic flag_s;
  logic status_s;
  logic [DATA_W-1:0] din_s;
  logic flag_busy;
  logic busy_edge;
  logic ready_edge;
  logic status_ok;
  logic gate_ok;
  logic take;
  logic refuse;

  phs_pin_sync #(.W(DATA_W + 2)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({periph_flag, periph_ok_status, periph_din}),
    .pin_out(sync_q)
  );

  assign flag_s = sync_q[DATA_W+1];
  assign status_s = sync_q[DATA_W];
  assign din_s = sync_q[DATA_W-1:0];

  // edges come from the synchronised level only
  assign flag_busy = (flag_s == cfg.flag_busy_high);
  assign busy_edge = flag_busy && !r_reg.flag_busy_q;
  assign ready_edge = !flag_busy && r_reg.flag_busy_q;
  assign status_ok = (status_s == cfg.status_ok_high);

  // pulse mode trusts a clear request alone; full mode also needs flag ready
  assign gate_ok = !r_reg.req_set && (cfg.pulse_mode || !flag_busy);
  assign xfer_ready = (r_reg.state == PHS_IDLE) && (r_reg.rst_cnt == '0) && gate_ok;
  assign refuse = xfer_valid && xfer_ready && xfer_first && cfg.status_check_en
    && !status_ok;
  assign take = xfer_valid && xfer_ready && !refuse;

  always_comb begin
    r_next = r_reg;
    r_next.flag_busy_q = flag_busy;
    r_next.done = 1'b0;
    r_next.status_err = 1'b0;
    if (int_enable_set) begin
      r_next.int_en = 1'b1;
    end
    if (aux_write) begin
      r_next.aux_a = aux_a_in;
      r_next.aux_b = aux_b_in;
    end
    if (r_reg.rst_cnt != '0) begin
      r_next.rst_cnt = r_reg.rst_cnt - PRESET_W'(1);
      r_next.preset_n = (r_reg.rst_cnt == PRESET_W'(1));
    end
    // the busy edge clears the request whatever state the handshake is in
    if (r_reg.req_set && busy_edge) begin
      r_next.req_set = 1'b0;
    end
    unique case (r_reg.state)
      PHS_IDLE: begin
        if (refuse) begin
          r_next.status_err = 1'b1;
        end else if (take) begin
          if (xfer_dir_in) begin
            r_next.dir_in = 1'b1;
            r_next.state = PHS_SETUP;
          end else begin
            r_next.dir_in = 1'b0;
            r_next.dout = xfer_wdata;
            r_next.delay_cnt = cfg.req_delay;
            r_next.state = PHS_DELAY;
          end
        end
      end
      PHS_SETUP: begin
        // direction has stood a full cycle before the request rises
        r_next.req_set = 1'b1;
        r_next.state = PHS_REQ;
      end
      PHS_DELAY: begin
        if (r_reg.delay_cnt == '0) begin
          r_next.req_set = 1'b1;
          r_next.state = PHS_REQ;
        end else begin
          r_next.delay_cnt = r_reg.delay_cnt - DELAY_W'(1);
        end
      end
      PHS_REQ: begin
        if (busy_edge) begin
          if (!r_reg.dir_in) begin
            r_next.done = 1'b1;
            r_next.state = PHS_IDLE;
          end else if (cfg.latch_on_flag_busy) begin
            r_next.din = din_s;
            r_next.done = 1'b1;
            r_next.state = PHS_IDLE;
          end else if (cfg.pulse_mode) begin
            // peripheral counts as ready once the request clears
            r_next.din = din_s;
            r_next.done = 1'b1;
            r_next.state = PHS_IDLE;
          end else begin
            r_next.state = PHS_WAIT_RDY;
          end
        end
      end
      PHS_WAIT_RDY: begin
        if (ready_edge) begin
          r_next.din = din_s;
          r_next.done = 1'b1;
          r_next.state = PHS_IDLE;
        end
      end
      // three state codes are unused; a corrupted state drops back to idle
      default: begin
        r_next.state = PHS_IDLE;
      end
    endcase
    // interface reset: aux lines and direction deliberately untouched
    if (iface_reset) begin
      r_next.state = PHS_IDLE;
      r_next.req_set = 1'b0;
      r_next.done = 1'b0;
      r_next.status_err = 1'b0;
      r_next.int_en = 1'b0;
      r_next.rst_cnt = PRESET_LOAD;
      r_next.preset_n = 1'b0;
      r_next.dir_in = r_reg.dir_in;
      r_next.aux_a = r_reg.aux_a;
      r_next.aux_b = r_reg.aux_b;
      if (cfg.dout_clear_fitted) begin
        r_next.dout = DOUT_RESET;
      end else begin
        r_next.dout = r_reg.dout;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg.state <= PHS_IDLE;
      r_reg.req_set <= 1'b0;
      r_reg.dir_in <= 1'b0;
      r_reg.dout <= DOUT_RESET;
      r_reg.din <= DOUT_RESET;
      r_reg.delay_cnt <= DELAY_RESET;
      r_reg.rst_cnt <= PRESET_LOAD;
      r_reg.preset_n <= 1'b0;
      r_reg.int_en <= 1'b0;
      r_reg.aux_a <= 1'b0;
      r_reg.aux_b <= 1'b0;
      r_reg.flag_busy_q <= 1'b0;
      r_reg.done <= 1'b0;
      r_reg.status_err <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign xfer_request = r_reg.req_set ? cfg.req_active_high : !cfg.req_active_high;
  assign periph_dir_in = r_reg.dir_in;
  assign periph_reset_n = r_reg.preset_n;
  assign periph_dout = r_reg.dout;
  assign xfer_rdata = r_reg.din;
  assign xfer_done = r_reg.done;
  assign status_error = r_reg.status_err;
  assign int_enable = r_reg.int_en;
  assign aux_control_out_a = r_reg.aux_a;
  assign aux_control_out_b = r_reg.aux_b;

  // helper: length of the current peripheral reset pulse
  logic [PRESET_W:0] low_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || r_reg.preset_n) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + (PRESET_W+1)'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence busy_edge_s;
    r_reg.req_set && busy_edge;
  endsequence

  sequence out_take_s;
    take && !xfer_dir_in;
  endsequence

  chk_full_ready_gate: assert property (
    (take && !cfg.pulse_mode) |-> (!flag_busy && !r_reg.req_set))
    else $error("full mode transfer started while peripheral not ready");

  chk_dir_before_req: assert property (
    ($rose(r_reg.req_set) && r_reg.dir_in) |-> $past(r_reg.dir_in))
    else $error("request raised before direction settled high");

  chk_busy_clears_req: assert property (
    busy_edge_s |=> !r_reg.req_set)
    else $error("flag busy edge did not clear request");

  chk_rdy_no_busy_latch: assert property (
    (busy_edge_s ##0 (r_reg.dir_in && !cfg.latch_on_flag_busy && !cfg.pulse_mode
      && !iface_reset)) |=> ($stable(r_reg.din) && r_reg.state == PHS_WAIT_RDY))
    else $error("ready-edge latch captured on busy edge");

  chk_pulse_skip_flag: assert property (
    (cfg.pulse_mode && r_reg.state == PHS_IDLE && r_reg.rst_cnt == '0
      && !r_reg.req_set) |-> xfer_ready)
    else $error("pulse mode waited on flag");

  chk_out_delay: assert property (
    (out_take_s ##0 (cfg.req_delay == 8'h00)) ##1 !iface_reset |=>
      (r_reg.req_set && !r_reg.dir_in))
    else $error("output request not raised after zero delay");

  chk_no_req_in_delay: assert property (
    (r_reg.state == PHS_DELAY) |-> (!r_reg.req_set && !r_reg.dir_in))
    else $error("request set during output delay");

  chk_dout_hold: assert property (
    (r_reg.req_set && $past(r_reg.req_set)) |-> $stable(r_reg.dout))
    else $error("output data changed while request set");

  chk_preset_len: assert property (
    $rose(r_reg.preset_n) |-> (low_cnt >= (PRESET_W+1)'(PRESET_CYCLES)))
    else $error("peripheral reset pulse too short");

  chk_reset_effects: assert property (
    iface_reset |=> (!r_reg.req_set && !r_reg.int_en && !r_reg.preset_n))
    else $error("interface reset left request or enable set");

  chk_dout_keep: assert property (
    (iface_reset && !cfg.dout_clear_fitted) |=> $stable(r_reg.dout))
    else $error("output data changed on reset without clear option");

  chk_aux_keep: assert property (
    (iface_reset && !aux_write) |=> ($stable(r_reg.aux_a) && $stable(r_reg.aux_b)
      && $stable(r_reg.dir_in)))
    else $error("reset disturbed aux or direction lines");

  chk_busy_latch: assert property (
    (busy_edge_s ##0 (r_reg.state == PHS_REQ && r_reg.dir_in && cfg.latch_on_flag_busy
      && !iface_reset)) |=> (r_reg.din == $past(din_s) && r_reg.done))
    else $error("busy-edge latch missed input data");

  chk_status_refuse: assert property (
    refuse |=> (r_reg.status_err && r_reg.state == PHS_IDLE && !r_reg.req_set))
    else $error("not-ok status did not block transfer");

  chk_input_setup: assert property (
    (take && xfer_dir_in && !iface_reset) |=>
      (r_reg.dir_in && r_reg.state == PHS_SETUP && !r_reg.req_set))
    else $error("input transfer did not set direction before request");

  chk_pulse_rdy_latch: assert property (
    (busy_edge_s ##0 (r_reg.state == PHS_REQ && r_reg.dir_in && !cfg.latch_on_flag_busy
      && cfg.pulse_mode && !iface_reset)) |=> (r_reg.din == $past(din_s) && r_reg.done))
    else $error("pulse mode ready-edge latch missed input data");

  chk_req_clear_cause: assert property (
    ($fell(r_reg.req_set) && $past(rst_n) && !$past(iface_reset)) |-> $past(busy_edge))
    else $error("request cleared without a flag busy edge");

  chk_ready_latch: assert property (
    (r_reg.state == PHS_WAIT_RDY && ready_edge && !iface_reset) |=>
      (r_reg.din == $past(din_s) && r_reg.done))
    else $error("ready-edge latch missed input data");

  chk_dout_load: assert property (
    (out_take_s ##0 !iface_reset) |=> (r_reg.dout == $past(xfer_wdata) && !r_reg.dir_in))
    else $error("output data or direction not set on take");

endmodule
`default_nettype wire

// ### testbench/phs_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module phs_periph_model
  import phs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_set,
  input wire logic busy_high,
  input wire logic [7:0] lag,
  input wire logic [DATA_W-1:0] send_word,
  input wire logic [DATA_W-1:0] dout,
  output logic flag,
  output logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] got_word
);
  logic busy;
  logic [7:0] cnt;
  logic [3:0] hold;
  assign flag = busy ? busy_high : !busy_high;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      hold <= 4'h0;
      din <= 16'hA5A5;
      got_word <= 16'h0000;
    end else if (busy) begin
      cnt <= cnt + 8'h01;
      if (cnt >= lag) begin
        busy <= 1'b0;
        cnt <= 8'h00;
        hold <= 4'h8;
      end
    end else if (req_set) begin
      // data settles lag cycles before busy, held until after ready
      din <= send_word;
      cnt <= cnt + 8'h01;
      if (cnt >= lag) begin
        busy <= 1'b1;
        cnt <= 8'h00;
        got_word <= dout;
      end
    end else begin
      // an abandoned request resets the count; stale data is inverted
      cnt <= 8'h00;
      if (hold == 4'h1) din <= ~din;
      if (hold != 4'h0) hold <= hold - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### testbench/test_parallel_handshake_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_parallel_handshake_port
  import phs_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  phs_cfg_t cfg = '0;
  logic iface_reset = 1'b0, xfer_valid = 1'b0, xfer_dir_in = 1'b0, xfer_first = 1'b0;
  logic int_enable_set = 1'b0, aux_write = 1'b0, aux_a_in = 1'b0, aux_b_in = 1'b0;
  logic st_bad = 1'b0;
  logic [7:0] lag = 8'h02;
  logic [DATA_W-1:0] xfer_wdata = 16'h0000, send_word = 16'h0000;
  logic xfer_ready, xfer_done, status_error, int_enable, periph_ok_status;
  logic aux_control_out_a, aux_control_out_b, periph_flag, xfer_request;
  logic periph_dir_in, periph_reset_n;
  logic [DATA_W-1:0] xfer_rdata, periph_din, periph_dout, got_word;
  int err_total = 0;
  int checks_done = 0;
  int seed = 32'he746cfca;
  logic [DATA_W-1:0] exp_q[$];
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  assign periph_ok_status = cfg.status_ok_high ^ st_bad;
  phs_port u_phs_port (.clk(clk), .rst_n(rst_n), .cfg(cfg), .iface_reset(iface_reset),
    .xfer_valid(xfer_valid), .xfer_dir_in(xfer_dir_in), .xfer_first(xfer_first),
    .xfer_wdata(xfer_wdata), .xfer_ready(xfer_ready), .xfer_done(xfer_done),
    .status_error(status_error), .xfer_rdata(xfer_rdata), .int_enable_set(int_enable_set),
    .int_enable(int_enable), .aux_write(aux_write), .aux_a_in(aux_a_in),
    .aux_b_in(aux_b_in), .aux_control_out_a(aux_control_out_a),
    .aux_control_out_b(aux_control_out_b), .periph_flag(periph_flag),
    .periph_ok_status(periph_ok_status), .periph_din(periph_din),
    .xfer_request(xfer_request), .periph_dir_in(periph_dir_in),
    .periph_reset_n(periph_reset_n), .periph_dout(periph_dout));
  phs_periph_model u_phs_periph_model (.clk(clk), .rst_n(rst_n),
    .req_set(xfer_request === cfg.req_active_high), .busy_high(cfg.flag_busy_high),
    .lag(lag), .send_word(send_word), .dout(periph_dout), .flag(periph_flag),
    .din(periph_din), .got_word(got_word));

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH at %0t ns: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wait_preset(input int slack);
    int c;
    c = 0;
    while (periph_reset_n !== 1'b1 && c < 400) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk(c + slack >= PRESET_CYCLES, 1'b1);
    chk(c <= PRESET_CYCLES + 1, 1'b1);
  endtask

  task automatic take(input logic dir, input logic first, input logic [DATA_W-1:0] w);
    int k;
    k = 0;
    xfer_dir_in = dir;
    xfer_first = first;
    xfer_wdata = w;
    send_word = w;
    xfer_valid = 1'b1;
    // ready is read once settled; the following edge takes the request
    while (xfer_ready !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(k < 3000, 1'b1);
    @(posedge clk);
    #1;
    xfer_valid = 1'b0;
  endtask

  task automatic xfer(input logic dir, input logic first, input logic [DATA_W-1:0] w);
    int c;
    int n;
    logic [DATA_W-1:0] e;
    c = 0;
    n = 0;
    exp_q.push_back(w);
    take(dir, first, w);
    while (xfer_done !== 1'b1 && status_error !== 1'b1 && c < 3000) begin
      @(posedge clk);
      #1;
      c++;
      if (n == 0 && xfer_request === cfg.req_active_high) begin
        n = c;
        chk(periph_dir_in, dir);
        chk(periph_flag === cfg.flag_busy_high && !cfg.pulse_mode, 1'b0);
      end
    end
    chk(c < 3000, 1'b1);
    e = exp_q.pop_front();
    if (status_error !== 1'b1) begin
      chk(16'(n), dir ? 16'h0001 : 16'(cfg.req_delay) + 16'h0001);
      chk(dir ? xfer_rdata : got_word, e);
      chk(xfer_request, !cfg.req_active_high);
    end
  endtask

  initial begin
    int i;
    int j;
    logic [DATA_W-1:0] w;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(xfer_ready, 1'b0);
    wait_preset(2);
    $display("test power_up done");
    for (i = 0; i < 8; i++) begin
      cfg.pulse_mode = i[0];
      cfg.latch_on_flag_busy = i[1];
      cfg.req_active_high = i[2];
      cfg.flag_busy_high = i[1] ^ i[2];
      // the first two modes run with no request delay at all
      cfg.req_delay = (i < 2) ? 8'h00 : 8'h01 + 8'($unsigned($random(seed)) % 6);
      lag = 8'h02 + 8'($unsigned($random(seed)) % 4);
      // let the synchronised flag settle after a polarity change
      repeat (6) @(posedge clk);
      #1;
      for (j = 0; j < 4; j++) begin
        xfer(j[1], 1'b0, 16'($random(seed)));
      end
      $display("test mode %0d done", i);
    end
    cfg.status_check_en = 1'b1;
    cfg.status_ok_high = 1'b1;
    st_bad = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    xfer(1'b0, 1'b1, 16'h1234);
    chk(status_error, 1'b1);
    chk(xfer_request, !cfg.req_active_high);
    xfer(1'b0, 1'b0, 16'h5A5A);
    st_bad = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    xfer(1'b0, 1'b1, 16'h4321);
    $display("test status_check done");
    // a slow peripheral keeps the request standing when reset hits
    lag = 8'hC8;
    for (i = 0; i < 2; i++) begin
      cfg.dout_clear_fitted = i[0];
      aux_a_in = 1'($random(seed));
      aux_b_in = !aux_a_in;
      aux_write = 1'b1;
      int_enable_set = 1'b1;
      @(posedge clk);
      #1;
      aux_write = 1'b0;
      int_enable_set = 1'b0;
      chk(int_enable, 1'b1);
      w = 16'($random(seed));
      take(1'b0, 1'b0, w);
      repeat (cfg.req_delay + 2) @(posedge clk);
      #1;
      chk(xfer_request, cfg.req_active_high);
      iface_reset = 1'b1;
      @(posedge clk);
      #1;
      iface_reset = 1'b0;
      chk(xfer_request, !cfg.req_active_high);
      chk(int_enable, 1'b0);
      chk({aux_control_out_a, aux_control_out_b, periph_dir_in}, {aux_a_in, aux_b_in, 1'b0});
      chk(periph_dout, i[0] ? 16'h0000 : w);
      chk(periph_reset_n, 1'b0);
      wait_preset(0);
      $display("test interface_reset %0d done", i);
    end
    wrap_up();
  end

  initial begin
    #(CLK_PERIOD_NS * 30000);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
